//--- src/tcsb_consts.vh
/*
 * Constants for the channel 3 status, buffer and output master enable slice.
 * Assumes an 8-bit register port addressed by byte offset.
 */
`ifndef TCSB_CONSTS_VH
`define TCSB_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define TCSB_OFF_STATUS     8'h85
`define TCSB_OFF_GRB_H      8'h8a
`define TCSB_OFF_GRB_L      8'h8b
`define TCSB_OFF_BRA_H      8'h8c
`define TCSB_OFF_BRA_L      8'h8d
`define TCSB_OFF_BRB_H      8'h8e
`define TCSB_OFF_BRB_L      8'h8f
`define TCSB_OFF_OUTEN      8'h90
`define TCSB_OFF_IRQ_STAT   8'h98
`define TCSB_OFF_IRQ_EN     8'h99
`define TCSB_OFF_IRQ_CLR    8'h9a

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define TCSB_BIT_OVF        2
`define TCSB_BIT_MFB        1
`define TCSB_BIT_MFA        0
`define TCSB_STAT_PAD       5'h1f
`define TCSB_OUTEN_PAD      2'h3
`define TCSB_OUTEN_RST      6'h3f
`define TCSB_WORD_RST       16'hffff
`define TCSB_CNT_MAX        16'hffff
`define TCSB_CNT_MIN        16'h0000
`define TCSB_IRQ_PAD        5'h00
`define TCSB_FLAGS_RST      3'h0
`define TCSB_OUTEN_OFF      6'h00
`define TCSB_RDATA_IDLE     8'h00

`endif

//--- src/tcsb_top.v
/*
 * Channel 3 status register, compare/capture register B, buffer registers
 * A and B, output master enables and a small interrupt block.
 * Assumes the counter, compare and capture logic sit elsewhere on the same
 * clock and present their events as one-cycle pulses.
 * Register port: byte address, write and read strobes, read data one
 * cycle after the read strobe and zero otherwise.
 * Status flags clear only after a read that saw them set; events win
 * over a same-cycle clear.
 */
// Our own choice: the plain strobed port.
`include "tcsb_consts.vh"

module tcsb_top #(
   parameter WIDTH = 16
) (
   // Clock and reset
   input  wire             clk_sys_in,
   input  wire             resetn_in,
   // Register port
   input  wire [7:0]       reg_addr_in,
   input  wire [7:0]       reg_wdata_in,
   input  wire             reg_wr_in,
   input  wire             reg_rd_in,
   output reg  [7:0]       reg_rdata_out,
   // Counter and channel events (same clock)
   input  wire             cnt_step_in,
   input  wire             cnt_down_in,
   input  wire [WIDTH-1:0] timer_count_in,
   input  wire             match_a_in,
   input  wire             match_b_in,
   input  wire             capture_b_in,
   input  wire             capture_mode_b_in,
   input  wire             ext_trigger_in,
   input  wire             pwm_sync_mode_in,
   // Pin outputs requested by I/O and function control
   input  wire [5:0]       pin_req_in,
   // Gated pin outputs, register B and buffer values, interrupt
   output wire [5:0]       pin_oe_out,
   output wire [WIDTH-1:0] compare_b_out,
   output wire [WIDTH-1:0] buffer_a_out,
   output wire [WIDTH-1:0] buffer_b_out,
   output wire             irq_out
);

   // ------------------------------------------------------------------
   // Registers and next values
   // ------------------------------------------------------------------
   reg [2:0]       flags_r;
   reg [2:0]       flags_nxt;
   reg [2:0]       armed_r;
   reg [2:0]       armed_nxt;
   reg [WIDTH-1:0] grb_r;
   reg [WIDTH-1:0] grb_nxt;
   reg [WIDTH-1:0] bra_r;
   reg [WIDTH-1:0] bra_nxt;
   reg [WIDTH-1:0] brb_r;
   reg [WIDTH-1:0] brb_nxt;
   reg [5:0]       outen_r;
   reg [5:0]       outen_nxt;
   reg [2:0]       irq_stat_r;
   reg [2:0]       irq_stat_nxt;
   reg [2:0]       irq_en_r;
   reg [2:0]       irq_en_nxt;
   reg [7:0]       rdata_nxt;

   // Decoded strobes and qualified events
   wire            wr_status;
   wire            rd_status;
   wire            wr_grb_h;
   wire            wr_grb_l;
   wire            wr_bra_h;
   wire            wr_bra_l;
   wire            wr_brb_h;
   wire            wr_brb_l;
   wire            wr_outen;
   wire            wr_irq_en;
   wire            wr_irq_clr;
   wire            wrap;
   wire            trig_clear;
   wire            capture_load;
   wire [2:0]      set_ev;

   // Register views as software reads them
   wire [7:0]      status_view;
   wire [7:0]      outen_view;
   wire [7:0]      irq_stat_view;
   wire [7:0]      irq_en_view;

   // ------------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------------
   // True when a strobe addresses the given byte offset
   function hit;
      input       strobe;
      input [7:0] addr;
      input [7:0] off;
      begin
         hit = strobe && (addr == off);
      end
   endfunction

   // Byte write of a 16-bit register half
   function [WIDTH-1:0] put_byte;
      input [WIDTH-1:0] cur;
      input [7:0]       dat;
      input             hi;
      begin
         if (hi) begin
            put_byte = {dat, cur[7:0]};
         end else begin
            put_byte = {cur[WIDTH-1:8], dat};
         end
      end
   endfunction

   // High or low byte of a 16-bit register
   function [7:0] byte_of;
      input [WIDTH-1:0] word;
      input             hi;
      begin
         if (hi) begin
            byte_of = word[WIDTH-1:8];
         end else begin
            byte_of = word[7:0];
         end
      end
   endfunction

   // ------------------------------------------------------------------
   // Register port decode
   // ------------------------------------------------------------------
   // Status strobes drive the read-then-write clear sequence
   assign wr_status  = hit(reg_wr_in, reg_addr_in, `TCSB_OFF_STATUS);
   assign rd_status  = hit(reg_rd_in, reg_addr_in, `TCSB_OFF_STATUS);

   // Byte writes of register B and the two buffers
   assign wr_grb_h   = hit(reg_wr_in, reg_addr_in, `TCSB_OFF_GRB_H);
   assign wr_grb_l   = hit(reg_wr_in, reg_addr_in, `TCSB_OFF_GRB_L);
   assign wr_bra_h   = hit(reg_wr_in, reg_addr_in, `TCSB_OFF_BRA_H);
   assign wr_bra_l   = hit(reg_wr_in, reg_addr_in, `TCSB_OFF_BRA_L);
   assign wr_brb_h   = hit(reg_wr_in, reg_addr_in, `TCSB_OFF_BRB_H);
   assign wr_brb_l   = hit(reg_wr_in, reg_addr_in, `TCSB_OFF_BRB_L);

   // Enable and interrupt control writes
   assign wr_outen   = hit(reg_wr_in, reg_addr_in, `TCSB_OFF_OUTEN);
   assign wr_irq_en  = hit(reg_wr_in, reg_addr_in, `TCSB_OFF_IRQ_EN);
   assign wr_irq_clr = hit(reg_wr_in, reg_addr_in, `TCSB_OFF_IRQ_CLR);

   // ------------------------------------------------------------------
   // Channel events
   // ------------------------------------------------------------------
   // Wrap from max to min counting up, or min to max counting down
   assign wrap = cnt_step_in &&
                 ((!cnt_down_in && timer_count_in == `TCSB_CNT_MAX) ||
                  (cnt_down_in && timer_count_in == `TCSB_CNT_MIN));
   // Flag layout: bit 2 overflow, bit 1 match B, bit 0 match A
   assign set_ev = {wrap, match_b_in, match_a_in};

   // Trigger only counts in the synchronised or complementary modes
   assign trig_clear   = ext_trigger_in && pwm_sync_mode_in;
   // Capture loads register B only in capture mode
   assign capture_load = capture_mode_b_in && capture_b_in;

   // ------------------------------------------------------------------
   // Status flags
   // ------------------------------------------------------------------
   // Clear needs a prior read seeing one; set wins over clear
   always @* begin
      armed_nxt = armed_r;
      flags_nxt = flags_r;
      if (rd_status) begin
         armed_nxt = armed_r | flags_r;
      end
      if (wr_status) begin
         flags_nxt = flags_r & ~(armed_r & ~reg_wdata_in[2:0]);
         armed_nxt = `TCSB_FLAGS_RST;
      end
      flags_nxt = flags_nxt | set_ev;
   end

   // Flag and arming flops
   always @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         flags_r <= `TCSB_FLAGS_RST;
         armed_r <= `TCSB_FLAGS_RST;
      end else begin
         flags_r <= flags_nxt;
         armed_r <= armed_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Register B and buffers
   // ------------------------------------------------------------------
   // Capture outranks a software write of register B in one cycle
   always @* begin
      grb_nxt = grb_r;
      bra_nxt = bra_r;
      brb_nxt = brb_r;
      if (capture_load) begin
         grb_nxt = timer_count_in;
      end else if (wr_grb_h) begin
         grb_nxt = put_byte(grb_r, reg_wdata_in, 1'b1);
      end else if (wr_grb_l) begin
         grb_nxt = put_byte(grb_r, reg_wdata_in, 1'b0);
      end
      if (wr_bra_h) begin
         bra_nxt = put_byte(bra_r, reg_wdata_in, 1'b1);
      end else if (wr_bra_l) begin
         bra_nxt = put_byte(bra_r, reg_wdata_in, 1'b0);
      end
      if (wr_brb_h) begin
         brb_nxt = put_byte(brb_r, reg_wdata_in, 1'b1);
      end else if (wr_brb_l) begin
         brb_nxt = put_byte(brb_r, reg_wdata_in, 1'b0);
      end
   end

   // Register B and buffer flops, all ones out of reset
   always @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         grb_r <= `TCSB_WORD_RST;
         bra_r <= `TCSB_WORD_RST;
         brb_r <= `TCSB_WORD_RST;
      end else begin
         grb_r <= grb_nxt;
         bra_r <= bra_nxt;
         brb_r <= brb_nxt;
      end
   end

   // Register values towards the compare and buffer logic
   assign compare_b_out = grb_r;
   assign buffer_a_out  = bra_r;
   assign buffer_b_out  = brb_r;

   // ------------------------------------------------------------------
   // Output master enables
   // ------------------------------------------------------------------
   // Trigger clear outranks a software write in the same cycle
   always @* begin
      outen_nxt = outen_r;
      if (trig_clear) begin
         outen_nxt = `TCSB_OUTEN_OFF;
      end else if (wr_outen) begin
         outen_nxt = reg_wdata_in[5:0];
      end
   end

   // Enable flops, all set out of reset
   always @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         outen_r <= `TCSB_OUTEN_RST;
      end else begin
         outen_r <= outen_nxt;
      end
   end

   // Bit 0 A3, 1 A4, 2 B4, 3 B3, 4 comp A4, 5 comp B4
   assign pin_oe_out = pin_req_in & outen_r;

   // ------------------------------------------------------------------
   // Interrupt status, enable and clear
   // ------------------------------------------------------------------
   // Sticky status; a new event wins over a same-cycle clear
   always @* begin
      irq_stat_nxt = irq_stat_r | set_ev;
      irq_en_nxt   = irq_en_r;
      if (wr_irq_clr) begin
         irq_stat_nxt = (irq_stat_r & ~reg_wdata_in[2:0]) | set_ev;
      end
      if (wr_irq_en) begin
         irq_en_nxt = reg_wdata_in[2:0];
      end
   end

   // Interrupt flops, quiet out of reset
   always @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         irq_stat_r <= `TCSB_FLAGS_RST;
         irq_en_r   <= `TCSB_FLAGS_RST;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         irq_en_r   <= irq_en_nxt;
      end
   end

   // Level interrupt while an enabled status bit is set
   assign irq_out = |(irq_stat_r & irq_en_r);

   // ------------------------------------------------------------------
   // Register views
   // ------------------------------------------------------------------
   // Unused status and enable bits read as one
   assign status_view   = {`TCSB_STAT_PAD, flags_r};
   assign outen_view    = {`TCSB_OUTEN_PAD, outen_r};
   // Interrupt registers pad with zero
   assign irq_stat_view = {`TCSB_IRQ_PAD, irq_stat_r};
   assign irq_en_view   = {`TCSB_IRQ_PAD, irq_en_r};

   // ------------------------------------------------------------------
   // Read data, one cycle after the strobe
   // ------------------------------------------------------------------
   // Read multiplexer; idle and unmapped reads give zero
   always @* begin
      rdata_nxt = `TCSB_RDATA_IDLE;
      if (reg_rd_in) begin
         case (reg_addr_in)
            `TCSB_OFF_STATUS:   rdata_nxt = status_view;
            `TCSB_OFF_GRB_H:    rdata_nxt = byte_of(grb_r, 1'b1);
            `TCSB_OFF_GRB_L:    rdata_nxt = byte_of(grb_r, 1'b0);
            `TCSB_OFF_BRA_H:    rdata_nxt = byte_of(bra_r, 1'b1);
            `TCSB_OFF_BRA_L:    rdata_nxt = byte_of(bra_r, 1'b0);
            `TCSB_OFF_BRB_H:    rdata_nxt = byte_of(brb_r, 1'b1);
            `TCSB_OFF_BRB_L:    rdata_nxt = byte_of(brb_r, 1'b0);
            `TCSB_OFF_OUTEN:    rdata_nxt = outen_view;
            `TCSB_OFF_IRQ_STAT: rdata_nxt = irq_stat_view;
            `TCSB_OFF_IRQ_EN:   rdata_nxt = irq_en_view;
            default:            rdata_nxt = `TCSB_RDATA_IDLE;
         endcase
      end
   end

   // Read data flop, stands for one cycle only
   always @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         reg_rdata_out <= `TCSB_RDATA_IDLE;
      end else begin
         reg_rdata_out <= rdata_nxt;
      end
   end

endmodule

//--- tb/tcsb_sva.sv
/* Port checker for tcsb_top.
   Assumes one clock and a synchronous active-low reset. */
module tcsb_sva #(parameter WIDTH = 16) (
   input wire             clk_sys_in, resetn_in, reg_wr_in, reg_rd_in, cnt_step_in,
   input wire             cnt_down_in, match_a_in, match_b_in, capture_b_in, irq_out,
   input wire             capture_mode_b_in, ext_trigger_in, pwm_sync_mode_in,
   input wire [7:0]       reg_addr_in, reg_wdata_in, reg_rdata_out,
   input wire [5:0]       pin_req_in, pin_oe_out,
   input wire [WIDTH-1:0] timer_count_in, compare_b_out, buffer_a_out, buffer_b_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);
   // Status read strobe and pin-disabling trigger
   wire rd_st = reg_rd_in && reg_addr_in == 8'h85;
   wire trg   = ext_trigger_in && pwm_sync_mode_in;
   AST_OVF_UP: assert property ((cnt_step_in && !cnt_down_in && timer_count_in == 16'hffff)
      ##1 rd_st |=> reg_rdata_out[2]) else $error("overflow not flagged");
   AST_OVF_DN: assert property ((cnt_step_in && cnt_down_in && timer_count_in == 16'h0000)
      ##1 rd_st |=> reg_rdata_out[2]) else $error("underflow not flagged");
   AST_STAT_PAD: assert property ($past(rd_st) |-> reg_rdata_out[7:3] == 5'h1f)
      else $error("status pad bits wrong");
   AST_OUTEN_PAD: assert property ($past(reg_rd_in) && $past(reg_addr_in) == 8'h90
      |-> reg_rdata_out[7:6] == 2'h3) else $error("enable pad bits wrong");
   AST_PIN_GATE: assert property ((pin_oe_out & ~pin_req_in) == 6'h00)
      else $error("pin enabled without request");
   AST_TRIG: assert property (trg |=> pin_oe_out == 6'h00)
      else $error("trigger left outputs on");
   AST_OUTEN_WR: assert property (reg_wr_in && reg_addr_in == 8'h90 && !trg
      |=> pin_oe_out == (pin_req_in & $past(reg_wdata_in[5:0]))) else $error("enable write lost");
   AST_CAPT: assert property (capture_b_in && capture_mode_b_in
      |=> compare_b_out == $past(timer_count_in)) else $error("capture lost");
   AST_BRA_H: assert property (reg_wr_in && reg_addr_in == 8'h8c
      |=> buffer_a_out[15:8] == $past(reg_wdata_in)) else $error("buffer A write lost");
   AST_BRB_L: assert property (reg_wr_in && reg_addr_in == 8'h8f
      |=> buffer_b_out[7:0] == $past(reg_wdata_in)) else $error("buffer B write lost");
   // Main scenarios reached
   cover property (trg);
   cover property (capture_b_in && capture_mode_b_in);
   cover property (irq_out);
endmodule
bind tcsb_top tcsb_sva #(.WIDTH(WIDTH)) i_sva (.*);

//--- tb/tcsb_top_test.sv
/* Self-checking bench for tcsb_top.
   Assumes the port checker is bound in from its own file. */
module tcsb_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_in = 0, resetn_in = 0, reg_wr_in = 0, reg_rd_in = 0, irq_out;
   logic cnt_step_in = 0, cnt_down_in = 0, match_a_in = 0, match_b_in = 0;
   logic capture_b_in = 0, capture_mode_b_in = 0, ext_trigger_in = 0, pwm_sync_mode_in = 0;
   logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
   logic [5:0] pin_req_in = 6'h3f, pin_oe_out;
   logic [15:0] timer_count_in = 16'h0000, compare_b_out, buffer_a_out, buffer_b_out;
   int miscompares = 0, n_compared = 0;
   tcsb_top #(.WIDTH(16)) i_dut (.*);
   always #4 clk_sys_in = ~clk_sys_in;
   // Compare and report
   task chk(input logic [15:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task summarize;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // One-cycle register write, then one-cycle read with check
   task wr(input logic [7:0] a, d);
      @(posedge clk_sys_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
      #1;
   endtask
   task rc(input logic [7:0] a, e);
      @(posedge clk_sys_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      #1 chk(reg_rdata_out, e);
   endtask
   // One-cycle event pulse from the rest of the timer
   task ev(input logic [15:0] c, input logic dn, st, ma, mb, cp, tg);
      @(posedge clk_sys_in);
      timer_count_in <= c;
      cnt_down_in <= dn;
      cnt_step_in <= st;
      match_a_in <= ma;
      match_b_in <= mb;
      capture_b_in <= cp;
      ext_trigger_in <= tg;
      @(posedge clk_sys_in);
      {cnt_step_in, match_a_in, match_b_in, capture_b_in, ext_trigger_in} <= 5'h00;
      #1;
   endtask
   task t_reset;
      rc(8'h85, 8'hf8);
      rc(8'h90, 8'hff);
      for (int a = 8'h8a; a <= 8'h8f; a++) rc(a[7:0], 8'hff);
      rc(8'h80, 8'h00);
      chk(pin_oe_out, 6'h3f);
   endtask
   task t_flags;
      ev(16'hffff, 0, 1, 0, 0, 0, 0);
      wr(8'h85, 8'hff);
      wr(8'h85, 8'hf8);
      rc(8'h85, 8'hfc);
      wr(8'h85, 8'hfb);
      rc(8'h85, 8'hf8);
      ev(16'h0000, 1, 1, 0, 0, 0, 0);
      ev(16'h1234, 0, 1, 1, 1, 0, 0);
      rc(8'h85, 8'hff);
      wr(8'h85, 8'hf8);
      rc(8'h85, 8'hf8);
      ev(16'hfffe, 0, 1, 0, 0, 0, 0);
      rc(8'h85, 8'hf8);
   endtask
   // Wrap then an immediate status read; a new wrap beats a same-cycle clear
   task t_b2b;
      @(posedge clk_sys_in);
      timer_count_in <= 16'h0000;
      cnt_down_in <= 1'b1;
      cnt_step_in <= 1'b1;
      @(posedge clk_sys_in);
      cnt_step_in <= 1'b0;
      reg_addr_in <= 8'h85;
      reg_rd_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      reg_wdata_in <= 8'hf8;
      reg_wr_in <= 1'b1;
      timer_count_in <= 16'hffff;
      cnt_down_in <= 1'b0;
      cnt_step_in <= 1'b1;
      #1 chk(reg_rdata_out, 8'hfc);
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
      cnt_step_in <= 1'b0;
      reg_rd_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      #1 chk(reg_rdata_out, 8'hfc);
   endtask
   task t_irq;
      wr(8'h9a, 8'h07);
      wr(8'h99, 8'h04);
      chk(irq_out, 1'b0);
      ev(16'hffff, 0, 1, 0, 0, 0, 0);
      chk(irq_out, 1'b1);
      wr(8'h99, 8'h00);
      chk(irq_out, 1'b0);
      wr(8'h99, 8'h04);
      ev(16'h1234, 0, 1, 1, 0, 0, 0);
      wr(8'h9a, 8'h04);
      chk(irq_out, 1'b0);
      rc(8'h98, 8'h01);
      rc(8'h99, 8'h04);
   endtask
   task t_regs;
      wr(8'h8c, 8'h12);
      wr(8'h8d, 8'h34);
      wr(8'h8e, 8'h56);
      wr(8'h8f, 8'h78);
      wr(8'h8a, 8'h9a);
      wr(8'h8b, 8'hbc);
      chk(buffer_a_out, 16'h1234);
      chk(buffer_b_out, 16'h5678);
      rc(8'h8b, 8'hbc);
      capture_mode_b_in <= 1'b1;
      ev(16'habcd, 0, 0, 0, 0, 1, 0);
      chk(compare_b_out, 16'habcd);
      capture_mode_b_in <= 1'b0;
      ev(16'h1111, 0, 0, 0, 0, 1, 0);
      chk(compare_b_out, 16'habcd);
   endtask
   task t_outen;
      for (int i = 0; i < 6; i++) begin
         wr(8'h90, 8'h01 << i);
         chk(pin_oe_out, 6'h01 << i);
         rc(8'h90, 8'hc0 | (8'h01 << i));
      end
      wr(8'h90, 8'hff);
      ev(16'h0000, 0, 0, 0, 0, 0, 1);
      chk(pin_oe_out, 6'h3f);
      pwm_sync_mode_in <= 1'b1;
      ev(16'h0000, 0, 0, 0, 0, 0, 1);
      rc(8'h90, 8'hc0);
      pin_req_in <= 6'h15;
      wr(8'h90, 8'h3f);
      chk(pin_oe_out, 6'h15);
   endtask
   // Watchdog for a hung run
   initial begin
      #100000;
      miscompares++;
      summarize;
   end
   // Main sequence
   initial begin
      repeat (12) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      t_reset;
      t_flags;
      t_b2b;
      t_irq;
      t_regs;
      t_outen;
      summarize;
   end
endmodule
